// file: pkg/codec_ctrl_pkg.sv
package codec_ctrl_pkg;

	// Serial framing
	localparam int          BITS_PER_BYTE    = 8;
	localparam logic [2:0]  LAST_BIT         = 3'h7;

	// Address byte field positions
	localparam int          ADDR_STANDBY_BIT = 7;
	localparam int          ADDR_REG_HI      = 6;
	localparam int          ADDR_REG_LO      = 3;
	localparam int          ADDR_READ_BIT    = 2;
	localparam int          ADDR_MORE_BIT    = 1;

	// Register numbers carried in the address byte
	localparam logic [3:0]  REG_CODING       = 4'h0;
	localparam logic [3:0]  REG_PCM          = 4'h1;
	localparam logic [3:0]  REG_RX_INJECT    = 4'h2;
	localparam logic [3:0]  REG_TX_INJECT    = 4'h3;
	localparam logic [3:0]  REG_AUX_FIRST    = 4'h4;
	localparam logic [3:0]  REG_BUTTON       = 4'ha;
	localparam logic [3:0]  REG_AUX_LAST     = 4'hb;
	localparam logic [3:0]  REG_TEST_FIRST   = 4'hc;
	localparam logic [3:0]  REG_TEST_LAST    = 4'he;

	// coding_config_reg fields
	localparam int          CC_RATE_HI       = 7;
	localparam int          CC_RATE_LO       = 6;
	localparam int          CC_TYPE          = 5;
	localparam int          CC_LAW_HI        = 4;
	localparam int          CC_LAW_LO        = 3;
	localparam int          CC_FORMAT        = 2;
	localparam int          CC_WIDTH         = 1;
	localparam int          CC_LOOP          = 0;

	// pcm_timing_reg fields
	localparam int          PT_TIMING_HI     = 7;
	localparam int          PT_TIMING_LO     = 6;
	localparam int          PT_LATCH         = 5;
	localparam int          PT_RX_SOURCE     = 4;
	localparam int          PT_ENABLE        = 2;
	localparam int          PT_CHANNEL       = 1;
	localparam int          PT_CLK_SOURCE    = 0;

	// button_detect_reg fields
	localparam int          BD_ENABLE        = 7;
	localparam int          BD_LATCH_MODE    = 6;
	localparam int          BD_INVERT        = 5;
	localparam int          BD_PRESSED       = 4;

	// Values after reset
	localparam logic [7:0]  CODING_RST       = 8'h00;
	localparam logic [7:0]  PCM_RST          = 8'h00;
	localparam logic [7:0]  BYTE_RST         = 8'h00;
	localparam logic        STANDBY_RST      = 1'b1;
	localparam logic [3:0]  PIN_SYNC_RST     = 4'h9;

	// Debounce timing
	localparam int          DEBOUNCE_MS      = 50;
	localparam int          REF_CLK_KHZ      = 250000;
	localparam int          DEBOUNCE_CYCLES  = DEBOUNCE_MS * REF_CLK_KHZ;

	typedef enum logic [0:0] {
		PH_ADDR = 1'b0,
		PH_DATA = 1'b1
	} phase_t;

endpackage : codec_ctrl_pkg

// file: hw/button_debounce.sv
`timescale 1ns/1ps
module button_debounce #(
	parameter int STABLE_CYCLES = 12500000,
	parameter int CNT_W         = $clog2(STABLE_CYCLES + 1)
) (
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_resetn,
	// Synchronised level in, filtered level out
	input  wire logic i_level,
	output logic      o_level
);

	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);

	logic [CNT_W-1:0] stable_cnt;

	// Runs whatever the power state; only a full quiet interval moves the output
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stable_cnt <= '0;
			o_level    <= 1'b1;
		end else if (i_level == o_level) begin
			stable_cnt <= '0;
		end else if (stable_cnt == CNT_LAST) begin
			stable_cnt <= '0;
			o_level    <= i_level;
		end else begin
			stable_cnt <= stable_cnt + CNT_W'(1);
		end
	end

endmodule : button_debounce

// file: hw/codec_control_port.sv
`timescale 1ns/1ps
module codec_control_port #(
	parameter int DEBOUNCE_CYCLES = codec_ctrl_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_resetn,
	// Serial control port
	input  wire logic       i_ctrl_select_n,
	input  wire logic       i_ctrl_clk,
	input  wire logic       i_ctrl_serial_in,
	output logic            o_ctrl_serial_out,
	output logic            o_ctrl_serial_out_oe_n,
	// Receive and transmit voice paths
	input  wire logic [7:0] i_rx_byte,
	input  wire logic       i_rx_byte_valid,
	output logic [7:0]      o_rx_inject,
	output logic [7:0]      o_tx_inject,
	output logic            o_tx_inject_load,
	// Headset button
	input  wire logic       i_button_in,
	output logic            o_button_out,
	// Power and configuration
	output logic            o_standby,
	output logic [1:0]      o_clk_rate_sel,
	output logic            o_code_type_sel,
	output logic [1:0]      o_code_law_sel,
	output logic            o_slot_format_sel,
	output logic            o_slot_width_sel,
	output logic            o_loopback_sel,
	output logic [1:0]      o_frame_timing_sel,
	output logic            o_aux_latch_out,
	output logic            o_rx_source_sel,
	output logic            o_voice_enable,
	output logic            o_channel_sel,
	output logic            o_clock_source_sel
);

	import codec_ctrl_pkg::*;

	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic       cclk_prev;
	logic       csn_s2;
	logic       cclk_s2;
	logic       ci_s2;
	logic       btn_s2;
	logic       sel_active;
	logic       clk_rise;
	logic       clk_fall;

	logic [7:0] shift_in;
	logic [2:0] bit_cnt;
	logic [7:0] next_byte;
	logic       byte_done;
	phase_t     phase;
	logic [3:0] cur_reg;
	logic       cur_read;
	logic       addr_done;
	logic       addr_starts_read;
	logic       write_stb;
	logic [7:0] out_shift;
	logic [7:0] rd_byte;
	logic [3:0] rd_sel;

	logic [7:0] coding_config_reg;
	logic [7:0] pcm_timing_reg;
	logic [7:0] rx_last;
	logic [7:0] aux_mem [REG_AUX_FIRST:REG_AUX_LAST];
	logic       bd_enable;
	logic       bd_latch_mode;
	logic       bd_invert;
	logic       pressed_latch;
	logic       stable_level;
	logic       deb_pressed;
	logic       shown_pressed;

	// Every pin is asynchronous to the reference clock
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_s1 <= PIN_SYNC_RST;
			pin_s2 <= PIN_SYNC_RST;
		end else begin
			pin_s1 <= {i_ctrl_select_n, i_ctrl_clk, i_ctrl_serial_in, i_button_in};
			pin_s2 <= pin_s1;
		end
	end

	assign csn_s2  = pin_s2[3];
	assign cclk_s2 = pin_s2[2];
	assign ci_s2   = pin_s2[1];
	assign btn_s2  = pin_s2[0];

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cclk_prev <= 1'b0;
		end else begin
			cclk_prev <= cclk_s2;
		end
	end

	assign sel_active = !csn_s2;
	assign clk_rise   = cclk_s2 && !cclk_prev;
	assign clk_fall   = !cclk_s2 && cclk_prev;
	assign next_byte  = {shift_in[6:0], ci_s2};
	assign byte_done  = sel_active && clk_rise && (bit_cnt == LAST_BIT);

	// A deselect mid-byte drops the partial bits; the byte phase is kept
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			shift_in <= BYTE_RST;
			bit_cnt  <= '0;
		end else if (!sel_active) begin
			bit_cnt  <= '0;
		end else if (clk_rise) begin
			shift_in <= next_byte;
			bit_cnt  <= bit_cnt + 3'h1;
		end
	end

	assign addr_done        = byte_done && (phase == PH_ADDR);
	assign addr_starts_read = addr_done && next_byte[ADDR_MORE_BIT] && next_byte[ADDR_READ_BIT];
	assign write_stb        = byte_done && (phase == PH_DATA) && !cur_read;
	assign rd_sel           = next_byte[ADDR_REG_HI:ADDR_REG_LO];

	// The second byte may follow in the same select or in a fresh one
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			phase    <= PH_ADDR;
			cur_reg  <= '0;
			cur_read <= 1'b0;
		end else if (byte_done) begin
			case (phase)
				PH_ADDR: begin
					if (next_byte[ADDR_MORE_BIT]) begin
						phase    <= PH_DATA;
						cur_reg  <= next_byte[ADDR_REG_HI:ADDR_REG_LO];
						cur_read <= next_byte[ADDR_READ_BIT];
					end
				end
				PH_DATA: begin
					phase <= PH_ADDR;
				end
				default: begin
					phase <= PH_ADDR;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_standby <= STANDBY_RST;
		end else if (addr_done) begin
			o_standby <= next_byte[ADDR_STANDBY_BIT];
		end
	end

	// Read-back source, chosen while the address byte completes
	always_comb begin
		rd_byte = BYTE_RST;
		if (rd_sel == REG_CODING) begin
			rd_byte = coding_config_reg;
		end else if (rd_sel == REG_PCM) begin
			rd_byte = pcm_timing_reg;
		end else if (rd_sel == REG_RX_INJECT) begin
			rd_byte = rx_last;
		end else if (rd_sel == REG_BUTTON) begin
			rd_byte = {bd_enable, bd_latch_mode, bd_invert, pressed_latch, 4'h0};
		end else if (rd_sel >= REG_AUX_FIRST && rd_sel <= REG_AUX_LAST) begin
			rd_byte = aux_mem[rd_sel];
		end else begin
			// Transmit injection, test registers and code 15 read as zero
			rd_byte = BYTE_RST;
		end
	end

	// The falling edge that closes the address byte already presents bit 7
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			out_shift         <= BYTE_RST;
			o_ctrl_serial_out <= 1'b0;
		end else if (addr_starts_read) begin
			out_shift <= rd_byte;
		end else if (sel_active && clk_fall && phase == PH_DATA && cur_read) begin
			o_ctrl_serial_out <= out_shift[7];
			out_shift         <= {out_shift[6:0], 1'b0};
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ctrl_serial_out_oe_n <= 1'b1;
		end else begin
			o_ctrl_serial_out_oe_n <= !(sel_active && phase == PH_DATA && cur_read);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			coding_config_reg <= CODING_RST;
		end else if (write_stb && cur_reg == REG_CODING) begin
			coding_config_reg <= next_byte;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pcm_timing_reg <= PCM_RST;
		end else if (write_stb && cur_reg == REG_PCM) begin
			pcm_timing_reg <= next_byte;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rx_inject <= BYTE_RST;
		end else if (write_stb && cur_reg == REG_RX_INJECT) begin
			o_rx_inject <= next_byte;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_last <= BYTE_RST;
		end else if (i_rx_byte_valid) begin
			rx_last <= i_rx_byte;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_tx_inject      <= BYTE_RST;
			o_tx_inject_load <= 1'b0;
		end else begin
			o_tx_inject_load <= write_stb && cur_reg == REG_TX_INJECT;
			if (write_stb && cur_reg == REG_TX_INJECT) begin
				o_tx_inject <= next_byte;
			end
		end
	end

	// Plain byte storage for the audio registers kept only for read-back
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = REG_AUX_FIRST; i <= REG_AUX_LAST; i++) begin
				aux_mem[i] <= BYTE_RST;
			end
		end else if (write_stb && cur_reg >= REG_AUX_FIRST && cur_reg <= REG_AUX_LAST
				&& cur_reg != REG_BUTTON) begin
			aux_mem[cur_reg] <= next_byte;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bd_enable     <= 1'b0;
			bd_latch_mode <= 1'b0;
			bd_invert     <= 1'b0;
		end else if (write_stb && cur_reg == REG_BUTTON) begin
			bd_enable     <= next_byte[BD_ENABLE];
			bd_latch_mode <= next_byte[BD_LATCH_MODE];
			bd_invert     <= next_byte[BD_INVERT];
		end
	end

	button_debounce #(
		.STABLE_CYCLES (DEBOUNCE_CYCLES)
	) u_debounce (
		.i_ref_clk (i_ref_clk),
		.i_resetn  (i_resetn),
		.i_level   (btn_s2),
		.o_level   (stable_level)
	);

	assign deb_pressed = !stable_level;

	// A press seen in the same cycle as a clearing write still sets the flag
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pressed_latch <= 1'b0;
		end else if (bd_enable && deb_pressed) begin
			pressed_latch <= 1'b1;
		end else if (write_stb && cur_reg == REG_BUTTON) begin
			pressed_latch <= 1'b0;
		end
	end

	assign shown_pressed = bd_latch_mode ? pressed_latch : deb_pressed;

	// Standby does not gate the monitor; a disabled monitor reports released
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_button_out <= 1'b0;
		end else if (bd_enable) begin
			o_button_out <= shown_pressed ^ bd_invert;
		end else begin
			o_button_out <= bd_invert;
		end
	end

	assign o_clk_rate_sel     = coding_config_reg[CC_RATE_HI:CC_RATE_LO];
	assign o_code_type_sel    = coding_config_reg[CC_TYPE];
	assign o_code_law_sel     = coding_config_reg[CC_LAW_HI:CC_LAW_LO];
	assign o_slot_format_sel  = coding_config_reg[CC_FORMAT];
	assign o_slot_width_sel   = coding_config_reg[CC_WIDTH];
	assign o_loopback_sel     = coding_config_reg[CC_LOOP];
	assign o_frame_timing_sel = pcm_timing_reg[PT_TIMING_HI:PT_TIMING_LO];
	assign o_aux_latch_out    = !pcm_timing_reg[PT_LATCH];
	// Injected receive data only makes sense for companded code
	assign o_rx_source_sel    = pcm_timing_reg[PT_RX_SOURCE] & coding_config_reg[CC_TYPE];
	assign o_voice_enable     = pcm_timing_reg[PT_ENABLE];
	assign o_channel_sel      = pcm_timing_reg[PT_CHANNEL] & coding_config_reg[CC_TYPE];
	assign o_clock_source_sel = pcm_timing_reg[PT_CLK_SOURCE];

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	AST_TWO_BYTE_ENTRY: assert property (
		addr_done && next_byte[ADDR_MORE_BIT] |=> phase == PH_DATA
	) else $error("address byte with data flag did not open data phase");

	AST_SINGLE_BYTE: assert property (
		addr_done && !next_byte[ADDR_MORE_BIT] |=> phase == PH_ADDR && $stable(coding_config_reg)
	) else $error("single byte command opened a data phase");

	AST_STANDBY_FOLLOWS: assert property (
		addr_done |=> o_standby == $past(next_byte[ADDR_STANDBY_BIT])
	) else $error("standby does not follow address bit 7");

	AST_WRITE_NEVER_DRIVES: assert property (
		phase == PH_DATA && !cur_read ##1 phase == PH_DATA |-> o_ctrl_serial_out_oe_n
	) else $error("serial out driven during a write");

	AST_RX_READBACK: assert property (
		addr_starts_read && rd_sel == REG_RX_INJECT |=> out_shift == $past(rx_last)
	) else $error("register 2 read-back is not the received byte");

	AST_TEST_NO_READBACK: assert property (
		addr_starts_read && rd_sel >= REG_TEST_FIRST && rd_sel <= REG_TEST_LAST
		|=> out_shift == BYTE_RST
	) else $error("test register returned data");

	AST_MSB_FIRST: assert property (
		sel_active && clk_fall && phase == PH_DATA && cur_read
		|=> o_ctrl_serial_out == $past(out_shift[7], 1)
	) else $error("read-back bit order wrong");

	AST_CODING_WRITE: assert property (
		write_stb && cur_reg == REG_CODING
		|=> o_clk_rate_sel == $past(next_byte[CC_RATE_HI:CC_RATE_LO]) ##1 $stable(o_clk_rate_sel)
	) else $error("clock rate field not written");

	AST_LATCH_POLARITY: assert property (
		write_stb && cur_reg == REG_PCM |=> o_aux_latch_out == !$past(next_byte[PT_LATCH])
	) else $error("latch output polarity wrong");

	AST_SLOT_COMPANDED: assert property (
		!o_code_type_sel |-> !o_channel_sel
	) else $error("second slot chosen in linear mode");

	AST_LATCH_CLEAR: assert property (
		write_stb && cur_reg == REG_BUTTON && !(bd_enable && deb_pressed) |=> !pressed_latch
	) else $error("pressed flag survived a write");

	AST_BUTTON_OUT: assert property (
		bd_enable && !bd_latch_mode |=> o_button_out == ($past(deb_pressed) ^ $past(bd_invert))
	) else $error("button output wrong in transparent mode");

	AST_DEBOUNCE_SOURCE: assert property (
		stable_level != $past(stable_level) |-> $past(btn_s2, 1) == stable_level
	) else $error("debounced level moved without input");

endmodule : codec_control_port

// file: verification/host_model.sv
`timescale 1ns/1ps
module host_model (
	// Serial control port, host side
	output logic      o_select_n,
	output logic      o_ctrl_clk,
	output logic      o_serial_in,
	input  wire logic i_serial_out,
	input  wire logic i_serial_out_oe_n
);
	initial begin
		o_select_n = 1'b1;
		o_ctrl_clk = 1'b0;
		o_serial_in = 1'b0;
	end

	// Read bits are taken at the rising edge, well after the falling edge launched them
	task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx, output logic oe_hi);
		oe_hi = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			o_serial_in = tx[i];
			#80;
			o_ctrl_clk = 1'b1;
			rx[i] = i_serial_out;
			oe_hi = oe_hi | (i_serial_out_oe_n !== 1'b0);
			#80;
			o_ctrl_clk = 1'b0;
		end
	endtask : shift_byte

	task automatic access(input logic [7:0] addr, input logic [7:0] data,
			output logic [7:0] rx, output logic oe_hi);
		logic [7:0] unused;
		logic       oe_a;
		rx = 8'h00;
		oe_hi = 1'b1;
		o_select_n = 1'b0;
		#41.3;
		shift_byte({addr[7:1], 1'b0}, unused, oe_a);
		if (addr[1]) begin
			shift_byte(data, rx, oe_hi);
		end
		#40;
		o_select_n = 1'b1;
		// A released data line must not keep showing its last level
		o_serial_in = ~o_serial_in;
		#80;
	endtask : access
endmodule : host_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import codec_ctrl_pkg::*;
	localparam int DEB = 16;
	logic       clk, rstn, sel_n, cclk, sdi, sdo, sdo_oe_n;
	logic [7:0] rx_byte, rx_inject, tx_inject;
	logic       rx_valid, tx_load, btn_in, btn_out, standby;
	logic [1:0] rate, law, ftime;
	logic       ctype, sfmt, swid, loopb, auxl, rxsrc, venab, chan, csrc;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         n_load = 0;

	codec_control_port #(.DEBOUNCE_CYCLES(DEB)) codec_control_port_inst (
		.i_ref_clk(clk), .i_resetn(rstn), .i_ctrl_select_n(sel_n), .i_ctrl_clk(cclk),
		.i_ctrl_serial_in(sdi), .o_ctrl_serial_out(sdo), .o_ctrl_serial_out_oe_n(sdo_oe_n),
		.i_rx_byte(rx_byte), .i_rx_byte_valid(rx_valid), .o_rx_inject(rx_inject),
		.o_tx_inject(tx_inject), .o_tx_inject_load(tx_load), .i_button_in(btn_in),
		.o_button_out(btn_out), .o_standby(standby), .o_clk_rate_sel(rate),
		.o_code_type_sel(ctype), .o_code_law_sel(law), .o_slot_format_sel(sfmt),
		.o_slot_width_sel(swid), .o_loopback_sel(loopb), .o_frame_timing_sel(ftime),
		.o_aux_latch_out(auxl), .o_rx_source_sel(rxsrc), .o_voice_enable(venab),
		.o_channel_sel(chan), .o_clock_source_sel(csrc));

	host_model host_model_inst (
		.o_select_n(sel_n), .o_ctrl_clk(cclk), .o_serial_in(sdi),
		.i_serial_out(sdo), .i_serial_out_oe_n(sdo_oe_n));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) if (tx_load === 1'b1) n_load <= n_load + 1;

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	function automatic logic [7:0] addr_of(logic pd, logic [3:0] rg, logic rd);
		return {pd, rg, rd, 1'b1, 1'b0};
	endfunction : addr_of

	task automatic wr(input logic pd, input logic [3:0] rg, input logic [7:0] d);
		logic [7:0] rx;
		logic       oe_hi;
		host_model_inst.access(addr_of(pd, rg, 1'b0), d, rx, oe_hi);
		tick(1);
	endtask : wr

	task automatic rd_check(input logic [3:0] rg, input logic [7:0] exp);
		logic [7:0] rx;
		logic       oe_hi;
		host_model_inst.access(addr_of(1'b0, rg, 1'b1), 8'h00, rx, oe_hi);
		tick(1);
		check("read data", rx, exp);
		check("read enable off", {7'h0, oe_hi}, 8'h00);
	endtask : rd_check

	// A press or release must not show before the full stable interval, and must show soon after
	task automatic wait_btn(input logic exp);
		int n;
		n = 0;
		while (btn_out !== exp && n < DEB + 12) begin
			tick(1);
			n++;
		end
		if (n == DEB + 12) begin
			check("button out", {7'h0, btn_out}, {7'h0, exp});
			close_out();
		end
		check("button early", {7'h0, n < DEB}, 8'h00);
	endtask : wait_btn

	task automatic t_reset;
		check("standby", {7'h0, standby}, 8'h01);
		check("coding outs", {rate, ctype, law, sfmt, swid, loopb}, 8'h00);
		check("timing outs", {ftime, auxl, rxsrc, venab, chan, csrc, 1'b0}, 8'h20);
		check("idle out", {btn_out, sdo_oe_n}, 8'h01);
	endtask : t_reset

	task automatic t_coding;
		logic [7:0] d;
		for (int k = 0; k < 4; k++) begin
			d = {4{k[1:0]}};
			wr(1'b0, REG_CODING, d);
			check("coding outs", {rate, ctype, law, sfmt, swid, loopb}, d);
			check("standby", {7'h0, standby}, 8'h00);
			rd_check(REG_CODING, d);
		end
	endtask : t_coding

	task automatic t_timing;
		logic [7:0] tbl [4] = '{8'h40, 8'h80, 8'hf7, 8'h32};
		wr(1'b0, REG_CODING, 8'h20);
		foreach (tbl[i]) begin
			wr(1'b0, REG_PCM, tbl[i]);
			check("timing outs", {ftime, auxl, rxsrc, venab, chan, csrc, 1'b0},
				{tbl[i][7:6], ~tbl[i][5], tbl[i][4], tbl[i][2:0], 1'b0});
			rd_check(REG_PCM, tbl[i]);
		end
		wr(1'b0, REG_CODING, 8'h00);
		check("linear gating", {6'h0, rxsrc, chan}, 8'h00);
	endtask : t_timing

	task automatic t_power;
		logic [7:0] rx;
		logic       oe_hi;
		host_model_inst.access(8'h80, 8'h00, rx, oe_hi);
		tick(1);
		check("standby", {7'h0, standby}, 8'h01);
		check("coding kept", {rate, ctype, law, sfmt, swid, loopb}, 8'h00);
		host_model_inst.access(8'h7c, 8'h00, rx, oe_hi);
		tick(1);
		check("standby", {7'h0, standby}, 8'h00);
	endtask : t_power

	task automatic t_inject;
		wr(1'b0, REG_RX_INJECT, 8'ha5);
		check("rx inject", rx_inject, 8'ha5);
		rx_byte = 8'h3c;
		rx_valid = 1'b1;
		tick(1);
		rx_valid = 1'b0;
		rd_check(REG_RX_INJECT, 8'h3c);
		n_load = 0;
		wr(1'b0, REG_TX_INJECT, 8'h69);
		check("tx inject", tx_inject, 8'h69);
		check("tx loads", 8'(n_load), 8'h01);
		rd_check(REG_TX_INJECT, 8'h00);
		wr(1'b0, REG_TEST_FIRST, 8'hff);
		check("coding kept", {rate, ctype, law, sfmt, swid, loopb}, 8'h00);
		rd_check(REG_TEST_FIRST, 8'h00);
		rd_check(REG_TEST_LAST, 8'h00);
	endtask : t_inject

	task automatic t_button;
		wr(1'b0, REG_BUTTON, 8'h80);
		check("released", {7'h0, btn_out}, 8'h00);
		btn_in = 1'b0;
		wait_btn(1'b1);
		btn_in = 1'b1;
		tick(DEB / 2);
		btn_in = 1'b0;
		tick(DEB + 8);
		check("glitch ignored", {7'h0, btn_out}, 8'h01);
		btn_in = 1'b1;
		wait_btn(1'b0);
		wr(1'b0, REG_BUTTON, 8'ha0);
		check("inverted", {7'h0, btn_out}, 8'h01);
		btn_in = 1'b0;
		wait_btn(1'b0);
		btn_in = 1'b1;
		wait_btn(1'b1);
		wr(1'b1, REG_BUTTON, 8'hc0);
		check("latch idle", {6'h0, standby, btn_out}, 8'h02);
		btn_in = 1'b0;
		wait_btn(1'b1);
		btn_in = 1'b1;
		tick(DEB + 8);
		check("latched", {7'h0, btn_out}, 8'h01);
		rd_check(REG_BUTTON, 8'hd0);
		wr(1'b0, REG_BUTTON, 8'hc0);
		check("latch cleared", {7'h0, btn_out}, 8'h00);
	endtask : t_button

	initial begin
		rstn = 1'b0;
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		btn_in = 1'b1;
		tick(6);
		rstn = 1'b1;
		tick(4);
		t_reset();
		t_coding();
		t_timing();
		t_power();
		t_inject();
		t_button();
		close_out();
	end
endmodule : tb_top
